// ---- pkg/sspt_pkg.sv ----
// Constants and types of the single-shot pulse timer.
// Assumes a 32-bit AXI4-Lite register port and one 100 MHz clock.
package sspt_pkg;

  localparam int unsigned CNT_W   = 16;
  localparam int unsigned ADDR_W  = 5;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_CTRL2  = 5'h04;
  localparam logic [4:0] OFF_EVCFG  = 5'h08;
  localparam logic [4:0] OFF_COUNT  = 5'h0c;
  localparam logic [4:0] OFF_CMP    = 5'h10;
  localparam logic [4:0] OFF_PRESC  = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;

  // Field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL2_EDGE_SELECT_A_BIT = 0;
  localparam int unsigned EVCFG_EDGE_BIT = 0;
  localparam int unsigned STATUS_RUN_BIT = 0;

  // Reset values and counter top
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CMP_RST   = 16'h0000;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  localparam logic [15:0] CNT_TOP   = 16'hffff;

  // Synchronous detector latency, event to output high
  localparam int unsigned SYNC_DELAY_CYC = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } sspt_state_e;

  typedef struct packed {
    logic        enable;
    logic        edgeSelectA;
    logic        anyEdge;
    logic [15:0] compareValue;
    logic [15:0] prescDiv;
  } sspt_cfg_s;

endpackage

// ---- hw/sspt_edge_detect.sv ----
// Trigger edge qualification for the single-shot pulse timer.
// Assumes the event input is synchronous to sys_clk.
`timescale 1ns/10ps
module sspt_edge_detect (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic eventIn,
  input  wire logic anyEdge,
  input  wire logic edgeSelectA,
  output logic      trigger
);

  logic prevQ;
  logic trigQ;
  logic riseNow;
  logic fallNow;
  logic edgeNow;

  assign riseNow = eventIn & ~prevQ;
  assign fallNow = ~eventIn & prevQ;
  assign edgeNow = riseNow | (anyEdge & fallNow);

  // Edge_select_a path acts in the event's own cycle; sync path adds one stage
  assign trigger = edgeSelectA ? edgeNow : trigQ;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prevQ <= 1'b0;
      trigQ <= 1'b0;
    end else begin
      prevQ <= eventIn;
      trigQ <= edgeNow;
    end
  end

endmodule

// ---- hw/sspt_timer.sv ----
// Single-shot pulse timer with AXI4-Lite register access.
// Assumes one clock, synchronous active-low reset, synchronous event input.
`timescale 1ns/10ps

module sspt_timer #(
  parameter int unsigned CW = sspt_pkg::CNT_W
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        eventIn,
  output logic             waveOut,
  output logic             running
);

  sspt_pkg::sspt_cfg_s   cfg_q;
  sspt_pkg::sspt_cfg_s   cfg_d;
  sspt_pkg::sspt_state_e state_q;
  sspt_pkg::sspt_state_e state_d;

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic [15:0]   prescCnt_q;
  logic [15:0]   prescCnt_d;
  logic          enablePrev_q;
  logic          waveOut_q;

  // Write and read channel holding registers
  logic          awHeld_q;
  logic [4:0]    awAddr_q;
  logic          wHeld_q;
  logic [31:0]   wData_q;
  logic [3:0]    wStrb_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;

  // ---------------- Bus decode ----------------
  wire doWrite = awHeld_q & wHeld_q & ~bvalid_q;
  wire wrCtrl  = doWrite & (awAddr_q == sspt_pkg::OFF_CTRL);
  wire wrCtrl2 = doWrite & (awAddr_q == sspt_pkg::OFF_CTRL2);
  wire wrEvcfg = doWrite & (awAddr_q == sspt_pkg::OFF_EVCFG);
  wire wrCount = doWrite & (awAddr_q == sspt_pkg::OFF_COUNT);
  wire wrCmp   = doWrite & (awAddr_q == sspt_pkg::OFF_CMP);
  wire wrPresc = doWrite & (awAddr_q == sspt_pkg::OFF_PRESC);
  wire wrStat  = doWrite & (awAddr_q == sspt_pkg::OFF_STATUS);
  wire wrHit   = wrCtrl | wrCtrl2 | wrEvcfg | wrCount | wrCmp |
                 wrPresc | wrStat;

  wire doRead  = arvalid & ~rvalid_q;
  wire rdCtrl  = araddr == sspt_pkg::OFF_CTRL;
  wire rdCtrl2 = araddr == sspt_pkg::OFF_CTRL2;
  wire rdEvcfg = araddr == sspt_pkg::OFF_EVCFG;
  wire rdCount = araddr == sspt_pkg::OFF_COUNT;
  wire rdCmp   = araddr == sspt_pkg::OFF_CMP;
  wire rdPresc = araddr == sspt_pkg::OFF_PRESC;
  wire rdStat  = araddr == sspt_pkg::OFF_STATUS;
  wire rdHit   = rdCtrl | rdCtrl2 | rdEvcfg | rdCount | rdCmp |
                 rdPresc | rdStat;

  // Byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  wire [15:0] cmpNew   = merge16(cfg_q.compareValue, wData_q, wStrb_q);
  wire [15:0] prescNew = merge16(cfg_q.prescDiv, wData_q, wStrb_q);
  wire [15:0] countNew = merge16(count_q, wData_q, wStrb_q);

  wire [31:0] rdMux =
      rdCtrl  ? {31'h0, cfg_q.enable}      :
      rdCtrl2 ? {31'h0, cfg_q.edgeSelectA} :
      rdEvcfg ? {31'h0, cfg_q.anyEdge}     :
      rdCount ? {16'h0, count_q}           :
      rdCmp   ? {16'h0, cfg_q.compareValue}:
      rdPresc ? {16'h0, cfg_q.prescDiv}    :
      rdStat  ? {31'h0, running}           :
                32'h0;

  // ---------------- Configuration ----------------
  always_comb begin
    cfg_d = cfg_q;
    if (wrCtrl && wStrb_q[0]) begin
      cfg_d.enable = wData_q[sspt_pkg::CTRL_EN_BIT];
    end
    if (wrCtrl2 && wStrb_q[0]) begin
      cfg_d.edgeSelectA = wData_q[sspt_pkg::CTRL2_EDGE_SELECT_A_BIT];
    end
    if (wrEvcfg && wStrb_q[0]) begin
      cfg_d.anyEdge = wData_q[sspt_pkg::EVCFG_EDGE_BIT];
    end
    if (wrCmp) begin
      cfg_d.compareValue = cmpNew;
    end
    if (wrPresc) begin
      cfg_d.prescDiv = prescNew;
    end
  end

  // ---------------- Trigger qualification ----------------
  logic trigger;

  sspt_edge_detect u_edge (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .eventIn     (eventIn),
    .anyEdge     (cfg_q.anyEdge),
    .edgeSelectA (cfg_q.edgeSelectA),
    .trigger     (trigger)
  );

  // Enable-time start, also covering the any-edge case at enable
  wire enableRise  = cfg_q.enable & ~enablePrev_q;
  wire notAtTop    = count_q != sspt_pkg::CNT_TOP;
  wire enableStart = enableRise & notAtTop;

  // Prescaled tick; divide value N gives one tick every N+1 clocks
  wire prescTick = prescCnt_q == cfg_q.prescDiv;
  wire cmpMatch  = count_q == cfg_q.compareValue;

  wire startReq  = cfg_q.enable & (trigger | enableStart);

  // ---------------- Pulse state machine ----------------
  always_comb begin
    state_d    = state_q;
    count_d    = count_q;
    prescCnt_d = prescTick ? 16'h0000 : prescCnt_q + 16'h0001;
    case (state_q)
      sspt_pkg::ST_IDLE: begin
        if (startReq) begin
          state_d    = sspt_pkg::ST_RUN;
          count_d    = '0;
          prescCnt_d = 16'h0000;
        end
      end
      sspt_pkg::ST_RUN: begin
        if (cmpMatch) begin
          // Prescaler restarts so the low time is a full period
          state_d    = sspt_pkg::ST_HOLD;
          prescCnt_d = 16'h0000;
        end else if (prescTick) begin
          count_d = count_q + CW'(1);
        end
      end
      sspt_pkg::ST_HOLD: begin
        // Triggers seen here fall through unused
        if (prescTick) begin
          state_d = sspt_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = sspt_pkg::ST_IDLE;
      end
    endcase
    if (!cfg_q.enable) begin
      state_d = sspt_pkg::ST_IDLE;
    end
    // Software write has priority over counting
    if (wrCount) begin
      count_d = countNew;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q        <= '{enable: 1'b0, edgeSelectA: 1'b0, anyEdge: 1'b0,
                        compareValue: sspt_pkg::CMP_RST,
                        prescDiv: sspt_pkg::PRESC_RST};
      state_q      <= sspt_pkg::ST_IDLE;
      count_q      <= sspt_pkg::CNT_RST;
      prescCnt_q   <= 16'h0000;
      enablePrev_q <= 1'b0;
      waveOut_q    <= 1'b0;
    end else begin
      cfg_q        <= cfg_d;
      state_q      <= state_d;
      count_q      <= count_d;
      prescCnt_q   <= prescCnt_d;
      enablePrev_q <= cfg_q.enable;
      waveOut_q    <= state_d == sspt_pkg::ST_RUN;
    end
  end

  assign waveOut = waveOut_q;
  assign running = state_q == sspt_pkg::ST_RUN;

  // ---------------- AXI4-Lite write ----------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 5'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= sspt_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {awaddr[4:2], 2'b00};
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wrHit ? sspt_pkg::RESP_OKAY : sspt_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign awready = ~awHeld_q & ~bvalid_q;
  assign wready  = ~wHeld_q & ~bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  // ---------------- AXI4-Lite read ----------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= sspt_pkg::RESP_OKAY;
    end else if (doRead) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdMux;
      rresp_q  <= rdHit ? sspt_pkg::RESP_OKAY : sspt_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign arready = ~rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

endmodule

// ---- bench/sspt_timer_assertions.sv ----
// Port checker for the single-shot pulse timer.
// Assumes it is bound onto sspt_timer.
`timescale 1ns/10ps
module sspt_timer_assertions (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        waveOut,
  input wire logic        running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_OUT_LOW: assert property (!running |-> !waveOut)
    else $error("output high while stopped");
  AST_OUT_HIGH: assert property (running |-> waveOut)
    else $error("output low while counting");
  AST_LOW_GAP: assert property ($fell(running) |=> !running)
    else $error("restart inside low time");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_B_REFUSE: assert property (bvalid |-> !awready && !wready)
    else $error("write ready during response");
  AST_R_REFUSE: assert property (rvalid |-> !arready)
    else $error("read ready during response");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  cover property ($fell(waveOut));
  cover property (bvalid && bresp == 2'b10);
  cover property (rvalid && rready);
endmodule

bind sspt_timer sspt_timer_assertions chk_u (
  .sys_clk, .rst_n, .awready, .wready, .bresp, .bvalid, .bready, .arvalid,
  .arready, .rdata, .rvalid, .rready, .waveOut, .running);

// ---- bench/sspt_event_src.sv ----
// Event channel model feeding trigger levels to the timer.
// Assumes callers sit just after a rising clock edge.
`timescale 1ns/10ps
module sspt_event_src (
  input  wire logic sys_clk,
  output logic      eventIn
);
  initial eventIn = 1'b0;
  // Gap lets a caller answer slowly
  task automatic toggle(input int gap);
    repeat (gap) @(posedge sys_clk);
    eventIn <= ~eventIn;
  endtask
endmodule

// ---- bench/single_shot_pulse_timer_bench.sv ----
// Self-checking bench for the single-shot pulse timer.
// Assumes the event model and the bound port checker.
`timescale 1ns/10ps
module single_shot_pulse_timer_bench;
  logic        sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic        eventIn, waveOut, running;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          err_count, compares, seed;

  sspt_timer dut_u (.sys_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .eventIn, .waveOut,
    .running);
  sspt_event_src ev_u (.sys_clk, .eventIn);

  always #5 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cyc(input string nm, input int e, g);
    compares++;
    if (g != e) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic ta, tw, tr, done;
    int   n;
    done = 1'b0;
    n = 0;
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && n < 40) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      done = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    // One edge apart, so a following call never re-raises in this step
    @(posedge sys_clk);
    if (!done) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    acc(1'b1, a, d, q, r);
    chk_val("bresp", 32'(sspt_pkg::RESP_OKAY), 32'(r));
  endtask

  task automatic setup(input logic asy, any, input logic [15:0] c, p, k);
    wr(sspt_pkg::OFF_CTRL, 32'h0);
    wr(sspt_pkg::OFF_CTRL2, 32'(asy));
    wr(sspt_pkg::OFF_EVCFG, 32'(any));
    wr(sspt_pkg::OFF_CMP, 32'(c));
    wr(sspt_pkg::OFF_PRESC, 32'(p));
    wr(sspt_pkg::OFF_COUNT, 32'(k));
    wr(sspt_pkg::OFF_CTRL, 32'h1);
  endtask

  function automatic int dly(logic asy, go);
    return !go ? 6 : (asy ? 1 : 2);
  endfunction

  function automatic int pw(logic [15:0] c, p);
    return int'(c) * (int'(p) + 1) + 1;
  endfunction

  initial begin
    logic [31:0] q, d;
    logic [1:0]  r;
    logic        asy, any, fall, go;
    logic [15:0] c, p;
    int          n, w;
    {sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {err_count, compares} = '0;
    seed = 58476;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Last offset is unmapped
    for (int k = 0; k < 8; k++) begin
      acc(1'b0, 5'(k * 4), 32'h0, q, r);
      chk_val("reset value", 32'h0, q);
      chk_val("rresp", k < 7 ? 32'h0 : 32'h2, 32'(r));
    end
    acc(1'b1, 5'h1c, 32'h1, q, r);
    chk_val("unmapped bresp", 32'h2, 32'(r));
    d = $random(seed);
    wr(sspt_pkg::OFF_COUNT, d);
    acc(1'b0, sspt_pkg::OFF_COUNT, 32'h0, q, r);
    chk_val("count", {16'h0, d[15:0]}, q);
    setup(1'b0, 1'b0, 16'h0030, 16'h0000, 16'hffff);
    acc(1'b0, sspt_pkg::OFF_STATUS, 32'h0, q, r);
    chk_val("status top", 32'h0, q);
    setup(1'b0, 1'b0, 16'h0030, 16'h0000, 16'h0005);
    acc(1'b0, sspt_pkg::OFF_STATUS, 32'h0, q, r);
    chk_val("status run", 32'h1, q);
    $display("test enable done");
    for (int m = 0; m < 16; m++) begin
      {fall, any, asy} = 3'(m);
      c = 16'($random(seed)) & 16'h0007;
      p = 16'($random(seed)) & 16'h0003;
      go = !fall || any;
      if (eventIn !== fall) ev_u.toggle(m % 3);
      setup(asy, any, c, p, 16'hffff);
      ev_u.toggle(0);
      n = 0;
      while (waveOut !== 1'b1 && n < 6) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk_cyc("delay", dly(asy, go), n);
      w = 0;
      while (waveOut === 1'b1 && w < 200) begin
        @(posedge sys_clk);
        if (w == 1 && c > 1) ev_u.toggle(0);
        #1;
        w++;
      end
      chk_cyc("width", go ? pw(c, p) : 0, w);
      if (w >= 200) complete_run();
      if (go && p > 1) begin
        @(posedge sys_clk);
        ev_u.toggle(0);
        w = 0;
        repeat (6) begin
          @(posedge sys_clk);
          #1;
          w += int'(waveOut === 1'b1);
        end
        chk_cyc("hold", 0, w);
      end
      $display("test %0d done", m);
    end
    complete_run();
  end
endmodule
